// ### verilog/torque_reach_output_conditioning.v
// torque reach detector, output polarity and braking settings with ahb-lite registers
//
// Function
// - output pair a is inverted when polarity bit 0 is set.
// - output pair b is inverted when polarity bit 1 is set.
// - output pair c is inverted when polarity bit 3 is set.
// - torque compared to a 3 to 300 percent threshold, default 100.
// - over-threshold must last longer than 1 to 1000 ms, default 10.
// - detect output turns on after qualification time has passed.
// - brake resistor settings survive a restore of defaults.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "torque_reach_defs.vh"
module torque_reach_output_conditioning #(
	parameter integer CYCLES_PER_MS = `CYCLES_PER_MS,
	parameter integer PRE_W         = 17,
	parameter integer TIME_W        = 10
) (
	input  wire        core_clk,
	input  wire        resetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire [15:0] torque_pct,
	input  wire        src_a,
	input  wire        src_b,
	input  wire        src_c,
	output reg         output_pair_a,
	output reg         output_pair_b,
	output reg         output_pair_c,
	output wire        torque_limit_detect_out,
	output wire        irq
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg  [15:0] output_polarity_select;
reg  [15:0] torque_reach_threshold;
reg  [15:0] torque_reach_time;
reg  [15:0] brake_resistor_ohms;
reg  [15:0] brake_resistor_watts;
reg  [2:0]  event_status;
reg  [2:0]  event_mask;
reg         detect_prev;
reg         wr_pend;
reg  [31:0] wr_addr;
reg  [31:0] next_rdata;
reg  [2:0]  next_status;
wire        over;
wire        reached;
wire        addr_phase;
wire [15:0] wval;
wire        hi_zero;
wire        wr_pol;
wire        wr_thr;
wire        wr_time;
wire        wr_ohms;
wire        wr_watts;
wire        wr_status;
wire        wr_mask;
wire        wr_ctrl;
wire        ok_pol;
wire        ok_thr;
wire        ok_time;
wire        ok_ohms;
wire        ok_watts;
wire        range_err;
wire        restore;
wire        ev_on;
wire        ev_off;
wire        rd_take;
wire        wr_take;
wire [1:0]  state_bits;
wire        take_pol;
wire        take_thr;
wire        take_time;
wire        take_ohms;
wire        take_watts;

// ----------------------------------------------------------------
// bus slave
// ----------------------------------------------------------------
// zero wait state slave, always OKAY
assign hreadyout  = 1'b1;
assign hresp      = 1'b0;
assign addr_phase = hsel && htrans[1] && hready && (hsize == 3'b010);
// writes land at the end of their data phase
assign rd_take    = addr_phase && !hwrite;
assign wr_take    = addr_phase && hwrite;

always @(posedge core_clk or negedge resetn) begin
	if (!resetn) begin
		wr_pend <= 1'b0;
		wr_addr <= 32'h0000_0000;
	end else if (hready) begin
		wr_pend <= wr_take;
		wr_addr <= haddr;
	end
end

// read data captured at the address phase
always @* begin
	next_rdata = 32'h0000_0000;
	if (haddr == `ADDR_POLARITY) begin
		next_rdata = {16'h0000, output_polarity_select};
	end else if (haddr == `ADDR_THRESHOLD) begin
		next_rdata = {16'h0000, torque_reach_threshold};
	end else if (haddr == `ADDR_REACH_TIME) begin
		next_rdata = {16'h0000, torque_reach_time};
	end else if (haddr == `ADDR_BRAKE_OHMS) begin
		next_rdata = {16'h0000, brake_resistor_ohms};
	end else if (haddr == `ADDR_BRAKE_WATTS) begin
		next_rdata = {16'h0000, brake_resistor_watts};
	end else if (haddr == `ADDR_EVENT_STATUS) begin
		next_rdata = {29'h0000_0000, event_status};
	end else if (haddr == `ADDR_EVENT_MASK) begin
		next_rdata = {29'h0000_0000, event_mask};
	end else if (haddr == `ADDR_STATE) begin
		next_rdata = {30'h0000_0000, state_bits};
	end
end

always @(posedge core_clk or negedge resetn) begin
	if (!resetn) begin
		hrdata <= 32'h0000_0000;
	end else if (rd_take) begin
		hrdata <= next_rdata;
	end
end

// ----------------------------------------------------------------
// write decode and range checks
// ----------------------------------------------------------------
assign wval      = hwdata[15:0];
assign hi_zero   = (hwdata[31:16] == 16'h0000);
assign wr_pol    = wr_pend && (wr_addr == `ADDR_POLARITY);
assign wr_thr    = wr_pend && (wr_addr == `ADDR_THRESHOLD);
assign wr_time   = wr_pend && (wr_addr == `ADDR_REACH_TIME);
assign wr_ohms   = wr_pend && (wr_addr == `ADDR_BRAKE_OHMS);
assign wr_watts  = wr_pend && (wr_addr == `ADDR_BRAKE_WATTS);
assign wr_status = wr_pend && (wr_addr == `ADDR_EVENT_STATUS);
assign wr_mask   = wr_pend && (wr_addr == `ADDR_EVENT_MASK);
assign wr_ctrl   = wr_pend && (wr_addr == `ADDR_CONTROL);

assign ok_pol   = hi_zero && (wval <= `MAX_POLARITY);
assign ok_thr   = hi_zero && (wval >= `MIN_THRESHOLD) && (wval <= `MAX_THRESHOLD);
assign ok_time  = hi_zero && (wval >= `MIN_REACH_TIME) && (wval <= `MAX_REACH_TIME);
assign ok_ohms  = hi_zero && (wval >= `MIN_BRAKE_OHMS) && (wval <= `MAX_BRAKE_OHMS);
// watts floor is zero: only the ceiling can be broken
assign ok_watts = hi_zero && (wval <= `MAX_BRAKE_WATTS);

// ----------------------------------------------------------------
// accepted writes
// ----------------------------------------------------------------
assign take_pol   = wr_pol && ok_pol;
assign take_thr   = wr_thr && ok_thr;
assign take_time  = wr_time && ok_time;
// brake values taken only by a write
assign take_ohms  = wr_ohms && ok_ohms;
assign take_watts = wr_watts && ok_watts;

// rejected writes raise the range event
assign range_err = (wr_pol && !ok_pol) || (wr_thr && !ok_thr) || (wr_time && !ok_time)
	|| (wr_ohms && !ok_ohms) || (wr_watts && !ok_watts);
assign restore   = wr_ctrl && hwdata[`CTRL_RESTORE];

// ----------------------------------------------------------------
// parameter registers
// ----------------------------------------------------------------
always @(posedge core_clk or negedge resetn) begin
	if (!resetn) begin
		output_polarity_select <= `RST_POLARITY;
		torque_reach_threshold <= `RST_THRESHOLD;
		torque_reach_time      <= `RST_REACH_TIME;
	end else if (restore) begin
		output_polarity_select <= `RST_POLARITY;
		torque_reach_threshold <= `RST_THRESHOLD;
		torque_reach_time      <= `RST_REACH_TIME;
	end else begin
		if (take_pol) begin
			output_polarity_select <= wval;
		end
		if (take_thr) begin
			torque_reach_threshold <= wval;
		end
		if (take_time) begin
			torque_reach_time <= wval;
		end
	end
end

always @(posedge core_clk or negedge resetn) begin
	if (!resetn) begin
		brake_resistor_ohms  <= `RST_BRAKE_OHMS;
		brake_resistor_watts <= `RST_BRAKE_WATTS;
	end else begin
		if (take_ohms) begin
			brake_resistor_ohms <= wval;
		end
		if (take_watts) begin
			brake_resistor_watts <= wval;
		end
	end
end

// ----------------------------------------------------------------
// torque reach detection
// ----------------------------------------------------------------
// compare torque to threshold
assign over = (torque_pct > torque_reach_threshold);
// state word: bit1 over threshold, bit0 detect
assign state_bits = {over, reached};

reach_timer #(
	.TIME_W   (TIME_W),
	.PRE_W    (PRE_W),
	.PRESCALE (CYCLES_PER_MS)
) u_reach_timer (
	.core_clk (core_clk),
	.resetn   (resetn),
	.over     (over),
	.limit_ms (torque_reach_time[TIME_W-1:0]),
	.reached  (reached)
);

assign torque_limit_detect_out = reached;

// ----------------------------------------------------------------
// output polarity
// ----------------------------------------------------------------
always @(posedge core_clk or negedge resetn) begin
	if (!resetn) begin
		output_pair_a <= 1'b0;
		output_pair_b <= 1'b0;
		output_pair_c <= 1'b0;
	end else begin
		// one cycle of latency on every pair
		// pair a, b and c polarity
		output_pair_a <= src_a ^ output_polarity_select[`POL_PAIR_A];
		output_pair_b <= src_b ^ output_polarity_select[`POL_PAIR_B];
		output_pair_c <= src_c ^ output_polarity_select[`POL_PAIR_C];
	end
end

// ----------------------------------------------------------------
// events and interrupt
// ----------------------------------------------------------------
// edges of the detect output
assign ev_on  = reached && !detect_prev;
assign ev_off = !reached && detect_prev;

// write one to clear, a new event wins
always @* begin
	next_status = event_status;
	if (wr_status) begin
		next_status = event_status & ~hwdata[2:0];
	end
	if (ev_on) begin
		next_status[`EVT_DETECT_ON] = 1'b1;
	end
	if (ev_off) begin
		next_status[`EVT_DETECT_OFF] = 1'b1;
	end
	if (range_err) begin
		next_status[`EVT_RANGE_ERR] = 1'b1;
	end
end

always @(posedge core_clk or negedge resetn) begin
	if (!resetn) begin
		detect_prev  <= 1'b0;
		event_status <= 3'h0;
		event_mask   <= 3'h0;
	end else begin
		detect_prev  <= reached;
		event_status <= next_status;
		if (wr_mask) begin
			event_mask <= hwdata[2:0];
		end
	end
end

assign irq = |(event_status & event_mask);

endmodule

// ### verilog/torque_reach_defs.vh
// constants for the torque reach and output conditioning block
`ifndef TORQUE_REACH_DEFS_VH
`define TORQUE_REACH_DEFS_VH

// ----------------------------------------------------------------
// register indices and byte addresses (byte address = 4 * index)
// ----------------------------------------------------------------
`define IDX_POLARITY      16'h3374
`define IDX_THRESHOLD     16'h3375
`define IDX_REACH_TIME    16'h3376
`define IDX_BRAKE_OHMS    16'h337b
`define IDX_BRAKE_WATTS   16'h337c
`define IDX_EVENT_STATUS  16'h3390
`define IDX_EVENT_MASK    16'h3391
`define IDX_CONTROL       16'h3392
`define IDX_STATE         16'h3393
`define ADDR_POLARITY     32'h0000_cdd0
`define ADDR_THRESHOLD    32'h0000_cdd4
`define ADDR_REACH_TIME   32'h0000_cdd8
`define ADDR_BRAKE_OHMS   32'h0000_cdec
`define ADDR_BRAKE_WATTS  32'h0000_cdf0
`define ADDR_EVENT_STATUS 32'h0000_ce40
`define ADDR_EVENT_MASK   32'h0000_ce44
`define ADDR_CONTROL      32'h0000_ce48
`define ADDR_STATE        32'h0000_ce4c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define POL_PAIR_A        0
`define POL_PAIR_B        1
`define POL_PAIR_C        3
`define EVT_DETECT_ON     0
`define EVT_DETECT_OFF    1
`define EVT_RANGE_ERR     2
`define CTRL_RESTORE      0

// ----------------------------------------------------------------
// reset values and legal ranges
// ----------------------------------------------------------------
`define RST_POLARITY      16'h0000
`define RST_THRESHOLD     16'h0064
`define RST_REACH_TIME    16'h000a
`define RST_BRAKE_OHMS    16'h0064
`define RST_BRAKE_WATTS   16'h0000
`define MAX_POLARITY      16'h000f
`define MIN_THRESHOLD     16'h0003
`define MAX_THRESHOLD     16'h012c
`define MIN_REACH_TIME    16'h0001
`define MAX_REACH_TIME    16'h03e8
`define MIN_BRAKE_OHMS    16'h000a
`define MAX_BRAKE_OHMS    16'h012c
`define MIN_BRAKE_WATTS   16'h0000
`define MAX_BRAKE_WATTS   16'h07d0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define MS_IN_NS          1000000
`define CYCLES_PER_MS     (`MS_IN_NS / `CLK_PERIOD_NS)

`endif

// ### verilog/reach_timer.v
// qualification timer: counts whole milliseconds while over threshold
`timescale 1ns/1ps
module reach_timer #(
	parameter integer TIME_W   = 10,
	parameter integer PRE_W    = 17,
	parameter integer PRESCALE = 100000
) (
	input  wire              core_clk,
	input  wire              resetn,
	input  wire              over,
	input  wire [TIME_W-1:0] limit_ms,
	output reg               reached
);

localparam integer      PRE_LAST_I = PRESCALE - 1;
localparam [PRE_W-1:0]  PRE_LAST   = PRE_LAST_I[PRE_W-1:0];
localparam [TIME_W-1:0] MS_SAT   = {TIME_W{1'b1}};

reg [PRE_W-1:0]  pre;
reg [TIME_W-1:0] ms_count;

always @(posedge core_clk or negedge resetn) begin
	if (!resetn) begin
		pre      <= {PRE_W{1'b0}};
		ms_count <= {TIME_W{1'b0}};
		reached  <= 1'b0;
	end else if (!over) begin
		pre      <= {PRE_W{1'b0}};
		ms_count <= {TIME_W{1'b0}};
		reached  <= 1'b0;
	end else begin
		if (pre == PRE_LAST) begin
			pre <= {PRE_W{1'b0}};
			if (ms_count != MS_SAT) begin
				ms_count <= ms_count + 1'b1;
			end
		end else begin
			pre <= pre + 1'b1;
		end
		reached <= (ms_count >= limit_ms);
	end
end

endmodule

// ### verification/torque_reach_props.sv
// assertion checker for the torque reach block
`timescale 1ns/1ps
module torque_reach_props #(
	parameter integer CYCLES_PER_MS = 100000
) (
	input wire        core_clk,
	input wire        resetn,
	input wire        hsel,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	input wire [15:0] torque_pct,
	input wire        src_a,
	input wire        src_b,
	input wire        src_c,
	input wire        output_pair_a,
	input wire        output_pair_b,
	input wire        output_pair_c,
	input wire        torque_limit_detect_out,
	input wire        irq
);
	reg [2:0]  wr_hist;
	reg [1:0]  warm;
	reg [31:0] hi_cnt;

	// ----------------------------------------
	// recent writes and over-torque run length
	// ----------------------------------------
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wr_hist <= 3'd0;
			warm <= 2'd0;
			hi_cnt <= 32'd0;
		end else begin
			wr_hist <= {wr_hist[1:0], hsel & htrans[1] & hready & hwrite};
			if (warm != 2'd3)
				warm <= warm + 2'd1;
			hi_cnt <= (torque_pct > 16'h0002) ? hi_cnt + 32'd1 : 32'd0;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	property p_pair_a;
		(warm == 2'd3 && wr_hist == 3'd0 && $stable(src_a)) |=> $stable(output_pair_a);
	endproperty
	property p_pair_b;
		(warm == 2'd3 && wr_hist == 3'd0 && $stable(src_b)) |=> $stable(output_pair_b);
	endproperty
	property p_pair_c;
		(warm == 2'd3 && wr_hist == 3'd0 && $stable(src_c)) |=> $stable(output_pair_c);
	endproperty
	property p_low_clear;
		(torque_pct <= 16'h0003) |=> !torque_limit_detect_out;
	endproperty
	property p_rise_time;
		$rose(torque_limit_detect_out) |-> hi_cnt >= CYCLES_PER_MS;
	endproperty
	property p_needs_over;
		torque_limit_detect_out |-> $past(torque_pct) > 16'h0002;
	endproperty
	property p_okay;
		hresp == 1'b0;
	endproperty
	property p_ready;
		hreadyout == 1'b1;
	endproperty

	a_pair_a: assert property (p_pair_a) else $error("pair a moved without cause");
	a_pair_b: assert property (p_pair_b) else $error("pair b moved without cause");
	a_pair_c: assert property (p_pair_c) else $error("pair c moved without cause");
	a_low_clear: assert property (p_low_clear) else $error("detect held at low torque");
	a_rise_time: assert property (p_rise_time) else $error("detect rose too early");
	a_needs_over: assert property (p_needs_over) else $error("detect without torque");
	a_okay: assert property (p_okay) else $error("bus response not okay");
	a_ready: assert property (p_ready) else $error("bus wait state seen");

	c_rise: cover property ($rose(torque_limit_detect_out));
	c_fall: cover property ($fell(torque_limit_detect_out));
	c_irq: cover property ($rose(irq));
endmodule

bind torque_reach_output_conditioning torque_reach_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_props (
	.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .torque_pct(torque_pct),
	.src_a(src_a), .src_b(src_b), .src_c(src_c), .output_pair_a(output_pair_a),
	.output_pair_b(output_pair_b), .output_pair_c(output_pair_c),
	.torque_limit_detect_out(torque_limit_detect_out), .irq(irq));

// ### verification/host_output_sampler.sv
// host-side sampler of the conditioned drive outputs
`timescale 1ns/1ps
module host_output_sampler (
	input  wire       core_clk,
	input  wire       a,
	input  wire       b,
	input  wire       c,
	input  wire       det,
	output reg  [3:0] seen
);
	initial seen = 4'h0;
	always @(posedge core_clk) begin
		seen <= {det, c, b, a};
	end
endmodule

// ### verification/torque_reach_output_conditioning_test.sv
// self-checking bench for the torque reach block
`timescale 1ns/1ps
`include "torque_reach_defs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module torque_reach_output_conditioning_test;
	localparam integer P = 10;
	reg        core_clk = 0, resetn = 0, hwrite = 0, src_a = 0, src_b = 0, src_c = 0;
	reg [1:0]  htrans = 0;
	reg [31:0] haddr = 0, hwdata = 0, rd, st = 32'h0000_261f;
	reg [15:0] torque_pct = 0, thr, t;
	wire       hready, det, irq, a, b, c;
	wire [31:0] hrdata;
	wire [3:0] seen;
	integer    err_count = 0, tests_run = 0, i, j, n;

	torque_reach_output_conditioning #(.CYCLES_PER_MS(P)) u_dut (.core_clk(core_clk), .resetn(resetn),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hresp(), .hrdata(hrdata), .torque_pct(torque_pct),
		.src_a(src_a), .src_b(src_b), .src_c(src_c), .output_pair_a(a), .output_pair_b(b),
		.output_pair_c(c), .torque_limit_detect_out(det), .irq(irq));
	host_output_sampler u_host (.core_clk(core_clk), .a(a), .b(b), .c(c), .det(det), .seen(seen));

	initial forever #5 core_clk = ~core_clk;

	function automatic [31:0] rnd();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		rnd = st;
	endfunction

	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task wait_rdy;
		n = 0;
		do begin @(posedge core_clk); n = n + 1; end while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1) begin err_count++; report_and_stop; end
	endtask

	task bus(input w, input [31:0] ad, input [31:0] d);
		haddr <= ad;
		hwrite <= w;
		htrans <= 2'b10;
		wait_rdy;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
	endtask

	task rchk(input [31:0] ad, input [31:0] e);
		bus(0, ad, 32'h0000_0000);
		`CHK("register", e, rd)
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		resetn <= 1;
		@(posedge core_clk);
		rchk(`ADDR_THRESHOLD, 32'h0000_0064);
		rchk(`ADDR_REACH_TIME, 32'h0000_000a);
		rchk(`ADDR_POLARITY, 32'h0000_0000);
		rchk(32'h0000_ce50, 32'h0000_0000);
		$display("done: reset values");
		for (i = 0; i < 16; i++) begin
			t = 16'(i) & 16'h000b;
			bus(1, `ADDR_POLARITY, {16'h0000, t});
			for (j = 0; j < 3; j++) begin
				rd = rnd();
				{src_c, src_b, src_a} <= rd[2:0];
				repeat (3) @(posedge core_clk);
				`CHK("pairs", {src_c ^ t[3], src_b ^ t[1], src_a ^ t[0]}, seen[2:0])
			end
		end
		$display("done: polarity");
		thr = 16'h0003 + 16'(rnd() % 298);
		bus(1, `ADDR_THRESHOLD, {16'h0000, thr});
		bus(1, `ADDR_REACH_TIME, 32'h0000_0002);
		bus(1, `ADDR_EVENT_MASK, 32'h0000_0007);
		torque_pct <= thr;
		repeat (40) @(posedge core_clk);
		`CHK("detect at threshold", 1'b0, det)
		torque_pct <= thr + 16'h0001;
		n = 0;
		do begin @(posedge core_clk); n = n + 1; end while (det !== 1'b1 && n < 200);
		`CHK("detect delay", 1'b1, (n >= 2 * P && n <= 2 * P + 3))
		torque_pct <= thr;
		repeat (2) @(posedge core_clk);
		`CHK("detect release", 1'b0, det)
		rchk(`ADDR_EVENT_STATUS, 32'h0000_0003);
		`CHK("irq raised", 1'b1, irq)
		bus(1, `ADDR_EVENT_STATUS, 32'h0000_0007);
		bus(1, `ADDR_THRESHOLD, 32'h0000_012d);
		rchk(`ADDR_THRESHOLD, {16'h0000, thr});
		bus(1, `ADDR_REACH_TIME, 32'h0000_0000);
		rchk(`ADDR_REACH_TIME, 32'h0000_0002);
		bus(1, `ADDR_EVENT_MASK, 32'h0000_0003);
		@(posedge core_clk);
		`CHK("irq masked", 1'b0, irq)
		rchk(`ADDR_EVENT_STATUS, 32'h0000_0004);
		bus(1, `ADDR_EVENT_STATUS, 32'h0000_0004);
		rchk(`ADDR_EVENT_STATUS, 32'h0000_0000);
		// one-cycle dip restarts the qualification count
		torque_pct <= thr + 16'h0001;
		repeat (15) @(posedge core_clk);
		`CHK("detect early", 1'b0, det)
		torque_pct <= thr;
		@(posedge core_clk);
		torque_pct <= thr + 16'h0001;
		n = 0;
		do begin @(posedge core_clk); n = n + 1; end while (det !== 1'b1 && n < 200);
		`CHK("detect restart", 1'b1, (n >= 2 * P && n <= 2 * P + 3))
		rchk(`ADDR_STATE, 32'h0000_0003);
		torque_pct <= 16'h0000;
		repeat (2) @(posedge core_clk);
		`CHK("detect low torque", 1'b0, det)
		rchk(`ADDR_STATE, 32'h0000_0000);
		$display("done: detector and events");
		t = 16'h000a + 16'(rnd() % 291);
		thr = 16'(rnd() % 2001);
		bus(1, `ADDR_BRAKE_OHMS, {16'h0000, t});
		bus(1, `ADDR_BRAKE_WATTS, {16'h0000, thr});
		bus(1, `ADDR_CONTROL, 32'h0000_0001);
		rchk(`ADDR_BRAKE_OHMS, {16'h0000, t});
		rchk(`ADDR_BRAKE_WATTS, {16'h0000, thr});
		rchk(`ADDR_THRESHOLD, 32'h0000_0064);
		rchk(`ADDR_REACH_TIME, 32'h0000_000a);
		rchk(`ADDR_POLARITY, 32'h0000_0000);
		$display("done: restore defaults");
		report_and_stop;
	end
endmodule
